// File: src/ecb_edge.sv
module ecb_edge
  import ecb_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise
);

  // ************************************************************
  // Rising edge detector
  // ************************************************************
  logic prev_q;

  // Previous sample; resets low so a level high at release counts once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;

endmodule : ecb_edge

// File: src/ecb_pkg.sv
package ecb_pkg;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int unsigned ECB_W16    = 16;
  localparam int unsigned ECB_W32    = 32;
  localparam int unsigned ECB_N16    = 4;
  localparam int unsigned ECB_N32    = 4;
  localparam int unsigned ECB_NUP32  = 2;

  // ************************************************************
  // Limits and reset values
  // ************************************************************
  localparam logic [15:0] ECB_MAX16   = 16'h7FFF;
  localparam logic [15:0] ECB_ZERO16  = 16'h0000;
  localparam logic [31:0] ECB_ZERO32  = 32'h0000_0000;
  localparam logic [31:0] ECB_ONE32   = 32'h0000_0001;
  localparam logic [31:0] ECB_MAX32   = 32'h7FFF_FFFF;

  // Software load of a present value
  typedef struct packed {
    logic        wr;
    logic [31:0] value;
  } ecb_load_t;

  // One counter's observed state
  typedef struct packed {
    logic        contact;
    logic [31:0] value;
  } ecb_state_t;

endpackage : ecb_pkg

// File: src/ecb_top.sv
module ecb_top
  import ecb_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [ECB_N16-1:0]   w_count,
  input  wire logic [ECB_N16-1:0]   w_clear,
  input  wire logic [15:0]          w_preset [ECB_N16],
  input  wire ecb_load_t            w_load   [ECB_N16],
  input  wire logic [ECB_N32-1:0]   d_count,
  input  wire logic [ECB_N32-1:0]   d_clear,
  input  wire logic [ECB_N32-1:0]   d_dir_down,
  input  wire logic [31:0]          d_preset [ECB_N32],
  input  wire ecb_load_t            d_load   [ECB_N32],
  input  wire logic [ECB_NUP32-1:0] u_count,
  input  wire logic [ECB_NUP32-1:0] u_clear,
  input  wire logic [31:0]          u_preset [ECB_NUP32],
  output ecb_state_t                w_state  [ECB_N16],
  output ecb_state_t                d_state  [ECB_N32],
  output ecb_state_t                u_state  [ECB_NUP32]
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Signed compare: at or above preset
  function automatic logic ecb_ge_s(input logic [31:0] a, input logic [31:0] b);
    return $signed(a) >= $signed(b);
  endfunction : ecb_ge_s

  // Word values are kept in 0..32767, so compare unsigned
  function automatic logic ecb_ge_w(input logic [15:0] a, input logic [15:0] b);
    return a >= b;
  endfunction : ecb_ge_w

  // ************************************************************
  // Word count-up counters
  // ************************************************************
  logic [15:0] wv_q [ECB_N16];
  logic [15:0] wv_d [ECB_N16];
  logic [ECB_N16-1:0] wc_q;
  logic [ECB_N16-1:0] wc_d;
  logic [ECB_N16-1:0] w_rise;

  for (genvar i = 0; i < ECB_N16; i++) begin : g_w
    logic [15:0] pre;
    logic [15:0] ld;
    logic        at_pre;
    logic        over;
    // Mask presets and loads to the legal word range (bit 15 dropped)
    // word range kept
    assign pre    = w_preset[i] & ECB_MAX16;
    assign ld     = w_load[i].value[15:0] & ECB_MAX16;
    assign at_pre = (wv_q[i] == pre);
    assign over   = ecb_ge_w(wv_q[i], pre) & ~at_pre;

    ecb_edge u_edge (
      .clk   (clk),
      .reset (reset),
      .level (w_count[i]),
      .rise  (w_rise[i])
    );

    // Next value: clear first, then load, then count
    always_comb begin
      wv_d[i] = wv_q[i];
      wc_d[i] = wc_q[i];
      if (w_clear[i]) begin
        wv_d[i] = ECB_ZERO16;
        wc_d[i] = 1'b0;
      end else if (w_load[i].wr) begin
        wv_d[i] = ld;
      end else if (w_rise[i]) begin
        if (over) begin
          wv_d[i] = pre;
          wc_d[i] = 1'b1;
        end else if (!at_pre) begin
          wv_d[i] = wv_q[i] + 16'h0001;
          // contact at preset, latched until clear
          wc_d[i] = wc_q[i] | ((wv_q[i] + 16'h0001) == pre);
        end
        // at preset the edge is ignored
      end
      if (!w_clear[i] && at_pre) begin
        wc_d[i] = wc_d[i] | (wv_d[i] == pre);
      end
    end

    assign w_state[i] = '{contact: wc_q[i], value: {16'h0000, wv_q[i]}};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ECB_N16; i++) begin
        wv_q[i] <= ECB_ZERO16;
      end
      wc_q <= '0;
    end else begin
      wv_q <= wv_d;
      wc_q <= wc_d;
    end
  end

  // ************************************************************
  // Double-word up/down counters
  // ************************************************************
  logic [31:0] dv_q [ECB_N32];
  logic [31:0] dv_d [ECB_N32];
  logic [ECB_N32-1:0] dc_q;
  logic [ECB_N32-1:0] dc_d;
  logic [ECB_N32-1:0] d_rise;

  for (genvar i = 0; i < ECB_N32; i++) begin : g_d
    logic [31:0] step;
    assign step = d_dir_down[i] ? (dv_q[i] - ECB_ONE32) : (dv_q[i] + ECB_ONE32);

    ecb_edge u_edge (
      .clk   (clk),
      .reset (reset),
      .level (d_count[i]),
      .rise  (d_rise[i])
    );

    // Contact follows the new value so it is valid in the same cycle
    always_comb begin
      dv_d[i] = dv_q[i];
      if (d_clear[i]) begin
        dv_d[i] = ECB_ZERO32;
      end else if (d_load[i].wr) begin
        dv_d[i] = d_load[i].value;
      end else if (d_rise[i]) begin
        // modular add wraps max to min
        dv_d[i] = step;
      end
      dc_d[i] = ~d_clear[i] & ecb_ge_s(dv_d[i], d_preset[i]);
    end

    assign d_state[i] = '{contact: dc_q[i], value: dv_q[i]};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ECB_N32; i++) begin
        dv_q[i] <= ECB_ZERO32;
      end
      dc_q <= '0;
    end else begin
      dv_q <= dv_d;
      dc_q <= dc_d;
    end
  end

  // ************************************************************
  // Double-word count-up-only counters
  // ************************************************************
  logic [31:0] uv_q [ECB_NUP32];
  logic [31:0] uv_d [ECB_NUP32];
  logic [ECB_NUP32-1:0] uc_q;
  logic [ECB_NUP32-1:0] uc_d;
  logic [ECB_NUP32-1:0] u_rise;

  for (genvar i = 0; i < ECB_NUP32; i++) begin : g_u
    ecb_edge u_edge (
      .clk   (clk),
      .reset (reset),
      .level (u_count[i]),
      .rise  (u_rise[i])
    );

    // Range is 0..max, so the wrap goes to zero, not negative
    always_comb begin
      uv_d[i] = uv_q[i];
      if (u_clear[i]) begin
        uv_d[i] = ECB_ZERO32;
      end else if (u_rise[i]) begin
        uv_d[i] = (uv_q[i] == ECB_MAX32) ? ECB_ZERO32 : (uv_q[i] + ECB_ONE32);
      end
      uc_d[i] = ~u_clear[i] & ecb_ge_s(uv_d[i], u_preset[i]);
    end

    assign u_state[i] = '{contact: uc_q[i], value: uv_q[i]};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ECB_NUP32; i++) begin
        uv_q[i] <= ECB_ZERO32;
      end
      uc_q <= '0;
    end else begin
      uv_q <= uv_d;
      uc_q <= uc_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [ECB_N16-1:0] w_cnt_prev_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      w_cnt_prev_q <= '0;
    end else begin
      w_cnt_prev_q <= w_count;
    end
  end

  steady_level_a: assert property (@(posedge clk) disable iff (reset)
    (w_count[0] && w_cnt_prev_q[0] && !w_clear[0] && !w_load[0].wr) |=> $stable(wv_q[0]))
    else $error("word counter moved on steady level");
  clear_zero_a: assert property (@(posedge clk) disable iff (reset)
    d_clear[0] |=> (dv_q[0] == ECB_ZERO32) && !dc_q[0])
    else $error("clear did not zero counter");
  hold_preset_a: assert property (@(posedge clk) disable iff (reset)
    (wv_q[0] == (w_preset[0] & ECB_MAX16) && !w_clear[0] && !w_load[0].wr)
      |=> wv_q[0] == $past(wv_q[0]))
    else $error("word counter passed preset");
  contact_hold_a: assert property (@(posedge clk) disable iff (reset)
    (wc_q[0] && !w_clear[0]) |=> wc_q[0])
    else $error("word contact dropped without clear");
  step_one_a: assert property (@(posedge clk) disable iff (reset)
    (d_rise[0] && !d_clear[0] && !d_load[0].wr && !d_dir_down[0])
      |=> dv_q[0] == $past(dv_q[0]) + ECB_ONE32)
    else $error("up step wrong");
  step_down_a: assert property (@(posedge clk) disable iff (reset)
    (d_rise[0] && !d_clear[0] && !d_load[0].wr && d_dir_down[0])
      |=> dv_q[0] == $past(dv_q[0]) - ECB_ONE32)
    else $error("down step wrong");
  contact_ge_a: assert property (@(posedge clk) disable iff (reset)
    dc_q[0] |-> $signed(dv_q[0]) >= $signed($past(d_preset[0])))
    else $error("contact on below preset");
  contact_below_a: assert property (@(posedge clk) disable iff (reset)
    (!dc_q[0] && !$past(d_clear[0]) && !$past(reset))
      |-> $signed(dv_q[0]) < $signed($past(d_preset[0])))
    else $error("contact off at or above preset");
  signed_wrap_a: assert property (@(posedge clk) disable iff (reset)
    (dv_q[0] == ECB_MAX32 && d_rise[0] && !d_dir_down[0] && !d_clear[0] && !d_load[0].wr)
      |=> dv_q[0] == 32'h8000_0000)
    else $error("signed wrap wrong");
  up_wrap_a: assert property (@(posedge clk) disable iff (reset)
    (uv_q[0] == ECB_MAX32 && u_rise[0] && !u_clear[0]) |=> uv_q[0] == ECB_ZERO32)
    else $error("up-only wrap wrong");

  reach_preset_c: cover property (@(posedge clk) disable iff (reset) $rose(wc_q[0]));
  count_down_c: cover property (@(posedge clk) disable iff (reset) d_rise[0] && d_dir_down[0]);
  contact_fall_c: cover property (@(posedge clk) disable iff (reset) $fell(dc_q[0]));

endmodule : ecb_top

// File: tb/ecb_prog.sv
// ****************************************
// Program-side count pulse source
// ****************************************
module ecb_prog
  import ecb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [7:0] n,
  input  wire logic       stay,
  output logic            level,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] cnt_q;

  // Odd phases drive high, so every pulse is followed by a low cycle
  assign level = stay | cnt_q[0];
  assign busy  = (cnt_q != 9'h000);

  // Two phases per pulse; stay gives a steady level instead
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 9'h000;
    end else if (go) begin
      cnt_q <= {n, 1'b0};
    end else if (busy) begin
      cnt_q <= cnt_q - 9'h001;
    end
  end
endmodule : ecb_prog

// File: tb/test_event_counter_bank.sv
// ****************************************
// Counter bank bench
// ****************************************
module test_event_counter_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import ecb_pkg::*;

  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             go = 1'b0;
  logic             stay = 1'b0;
  logic [7:0]       n = 8'h00;
  logic             lvl;
  logic             busy;
  logic [3:0]       w_sel = 4'h0;
  logic [3:0]       w_clear = 4'h0;
  logic [3:0]       d_sel = 4'h0;
  logic [3:0]       d_clear = 4'h0;
  logic [3:0]       d_dir_down = 4'h0;
  logic [1:0]       u_sel = 2'h0;
  logic [1:0]       u_clear = 2'h0;
  logic [15:0]      w_preset [ECB_N16];
  logic [31:0]      d_preset [ECB_N32];
  logic [31:0]      u_preset [ECB_NUP32];
  ecb_load_t        w_load   [ECB_N16];
  ecb_load_t        d_load   [ECB_N32];
  ecb_state_t       w_state  [ECB_N16];
  ecb_state_t       d_state  [ECB_N32];
  ecb_state_t       u_state  [ECB_NUP32];
  int               fail_count = 0;
  int               checks_done = 0;

  // One pulse source, steered to whichever lanes a scenario selects
  wire [3:0] w_count = w_sel & {4{lvl}};
  wire [3:0] d_count = d_sel & {4{lvl}};
  wire [1:0] u_count = u_sel & {2{lvl}};

  always #10 clk = ~clk;

  ecb_prog i_ecb_prog (.clk(clk), .reset(reset), .go(go), .n(n), .stay(stay),
    .level(lvl), .busy(busy));

  ecb_top i_ecb_top (.clk(clk), .reset(reset), .w_count(w_count), .w_clear(w_clear),
    .w_preset(w_preset), .w_load(w_load), .d_count(d_count), .d_clear(d_clear),
    .d_dir_down(d_dir_down), .d_preset(d_preset), .d_load(d_load), .u_count(u_count),
    .u_clear(u_clear), .u_preset(u_preset), .w_state(w_state), .d_state(d_state),
    .u_state(u_state));

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task chk(input ecb_state_t g, input ecb_state_t e, input string m);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Pulse train, then two edges for the registered state to land
  task pulses(input logic [7:0] k);
    int t;
    n <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (t = 0; busy && t < 600; t++) @(posedge clk);
    if (busy) begin
      fail_count++;
      $display("mismatch %0t pulse train did not finish", $time);
      conclude();
    end
    repeat (2) @(posedge clk);
  endtask : pulses

  task load(input bit dbl, input int i, input logic [31:0] v);
    if (dbl) d_load[i] <= '{1'b1, v};
    else w_load[i] <= '{1'b1, v};
    @(posedge clk);
    d_load[i].wr <= 1'b0;
    w_load[i].wr <= 1'b0;
    @(posedge clk);
  endtask : load

  task t_word;
    w_preset[0] <= 16'h0005;
    w_sel <= 4'h1;
    pulses(8'h04);
    chk(w_state[0], '{1'b0, 32'h0000_0004}, "word below preset");
    pulses(8'h03);
    chk(w_state[0], '{1'b1, 32'h0000_0005}, "word stop at preset");
    w_clear <= 4'h1;
    @(posedge clk);
    w_clear <= 4'h0;
    repeat (2) @(posedge clk);
    chk(w_state[0], '{1'b0, 32'h0000_0000}, "word clear");
    $display("t_word done");
  endtask : t_word

  task t_over;
    w_preset[1] <= 16'h0003;
    w_sel <= 4'h2;
    load(1'b0, 1, 32'h0000_8009);
    chk(w_state[1], '{1'b0, 32'h0000_0009}, "word load width");
    pulses(8'h01);
    chk(w_state[1], '{1'b1, 32'h0000_0003}, "word over preset");
    $display("t_over done");
  endtask : t_over

  task t_updown;
    d_preset[0] <= 32'hFFFF_FFFB;
    d_sel <= 4'h1;
    load(1'b1, 0, 32'hFFFF_FFF9);
    pulses(8'h01);
    chk(d_state[0], '{1'b0, 32'hFFFF_FFFA}, "updown up one");
    pulses(8'h01);
    chk(d_state[0], '{1'b1, 32'hFFFF_FFFB}, "updown reach");
    pulses(8'h01);
    d_dir_down <= 4'h1;
    d_sel <= 4'h3;
    pulses(8'h02);
    chk(d_state[0], '{1'b0, 32'hFFFF_FFFA}, "updown down below");
    chk(d_state[1], '{1'b1, 32'h0000_0002}, "other lane up");
    d_dir_down <= 4'h0;
    d_sel <= 4'h1;
    load(1'b1, 0, 32'h7FFF_FFFF);
    pulses(8'h01);
    chk(d_state[0], '{1'b0, 32'h8000_0000}, "updown wrap");
    $display("t_updown done");
  endtask : t_updown

  task t_misc;
    u_preset[0] <= 32'h0000_0002;
    u_sel <= 2'h1;
    pulses(8'h03);
    chk(u_state[0], '{1'b1, 32'h0000_0003}, "uponly past preset");
    u_sel <= 2'h0;
    d_sel <= 4'h8;
    w_sel <= 4'h1;
    stay <= 1'b1;
    repeat (6) @(posedge clk);
    stay <= 1'b0;
    repeat (3) @(posedge clk);
    chk(d_state[3], '{1'b1, 32'h0000_0001}, "steady level once");
    chk(w_state[0], '{1'b0, 32'h0000_0001}, "word steady level once");
    $display("t_misc done");
  endtask : t_misc

  // Clear wins for one cycle; the up/down contact then follows its preset again
  task t_clear;
    d_clear <= 4'h1;
    u_clear <= 2'h1;
    @(posedge clk);
    d_clear <= 4'h0;
    u_clear <= 2'h0;
    @(posedge clk);
    chk(d_state[0], '{1'b0, 32'h0000_0000}, "updown clear");
    chk(u_state[0], '{1'b0, 32'h0000_0000}, "uponly clear");
    @(posedge clk);
    chk(d_state[0], '{1'b1, 32'h0000_0000}, "updown contact after clear");
    $display("t_clear done");
  endtask : t_clear

  initial begin
    foreach (w_preset[i]) w_preset[i] = 16'h7FFF;
    foreach (w_load[i]) w_load[i] = '0;
    foreach (d_preset[i]) d_preset[i] = 32'h0000_0000;
    foreach (d_load[i]) d_load[i] = '0;
    foreach (u_preset[i]) u_preset[i] = 32'h0000_0000;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_word();
    t_over();
    t_updown();
    t_misc();
    t_clear();
    conclude();
  end
endmodule : test_event_counter_bank
